// >>> common/gtc_defines.svh
// Notes on behaviour
// - A timer counts only while its run bit is one.
// - With halt-in-idle set, the timer stops while the device idles.
// - With write block set, count writes are ignored while one is pending.
// - Write-pending reads one during an asynchronous count write, else zero.
// - External select: 00 secondary oscillator, 01 pin, 10 low-power RC, 11 reserved.
// - Standalone gate enable acts only with the internal clock.
// - Standalone prescale codes 00..11 divide by 1, 8, 64, 256.
// - Wide mode joins odd and even timers into one 32-bit counter.
// - Wide mode bit exists only in the even timer control register.
// - Even clock source bit: one selects its pin, zero the internal clock.
// - In wide mode the even timer settings and the odd halt-in-idle bit control the whole counter.
// - Paired prescale codes 000..111 divide by 1,2,4,8,16,32,64,256.
// - Odd clock source bit: one selects its pin, zero the internal clock.
// - Odd gate enable acts only with the internal clock.
//
// Register offsets, field positions, write masks and reset values.
// Assumes a 32-bit Wishbone slave decoding eight byte-address bits.
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

`define GTC_ADDR_W    8
`define GTC_OFS_CTL1  8'h00
`define GTC_OFS_CNT1  8'h04
`define GTC_OFS_CTL2  8'h08
`define GTC_OFS_CTL3  8'h0C
`define GTC_OFS_CNT2  8'h10
`define GTC_OFS_CNT3  8'h14

`define GTC_B_RUN     15
`define GTC_B_HALT    13
`define GTC_B_WBLK    12
`define GTC_B_WPEND   11
`define GTC_B_EXT     8
`define GTC_B_GATE    7
`define GTC_B_PS      4
`define GTC_B_WIDE    3
`define GTC_B_SYNC    2
`define GTC_B_CSRC    1

`define GTC_MASK_CTL1 16'hB3B6
`define GTC_MASK_CTL2 16'hA0FA
`define GTC_MASK_CTL3 16'hA0F2
`define GTC_RST_CTL   16'h0000
`define GTC_RST_CNT   16'h0000

`endif

// >>> common/gtc_pkg.sv
// Types and shared decode functions of the general timer control block.
// Assumes gtc_defines.svh is on the include path.
`include "gtc_defines.svh"

package gtc_pkg;

   // Classic Wishbone request from the master.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } gtc_wb_req_t;

   // Clock and gate sources, all synchronous to the system clock.
   typedef struct packed {
      logic secondaryOscillator;
      logic lowPowerRcOsc;
      logic standaloneExtClockPin;
      logic evenExtClockPin;
      logic oddExtClockPin;
   } gtc_clk_in_t;

   // External source codes of the standalone timer.
   typedef enum logic [1:0] {
      EXT_SECONDARY_OSCILLATOR = 2'b00,
      EXT_PIN  = 2'b01,
      EXT_LOW_POWER_RC_OSC = 2'b10,
      EXT_RSVD = 2'b11
   } gtc_ext_src_t;

   // Standalone prescale code to a power-of-two shift.
   function automatic logic [3:0] soloShift(input logic [1:0] code);
      unique case (code)
         2'b00: soloShift = 4'h0;
         2'b01: soloShift = 4'h3;
         2'b10: soloShift = 4'h6;
         2'b11: soloShift = 4'h8;
      endcase
   endfunction : soloShift

   // Paired prescale code to a power-of-two shift; the top code skips 128.
   function automatic logic [3:0] pairShift(input logic [2:0] code);
      pairShift = (code == 3'b111) ? 4'h8 : {1'b0, code};
   endfunction : pairShift

   // Merges write data into a 16-bit register under byte enables and a mask.
   function automatic logic [15:0] wbMerge(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel,
                                           input logic [15:0] mask);
      logic [15:0] bytes;
      bytes = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      wbMerge = bytes & mask;
   endfunction : wbMerge

endpackage : gtc_pkg

// >>> design/gtc_timer_core.sv
// One counter with its prescaler.
// Assumes srcTick marks one source clock event per system clock cycle.
`timescale 1ns/100ps

module gtc_timer_core #(
   parameter int WIDTH = 16
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             run,
   input  wire logic             srcTick,
   input  wire logic             gateOk,
   input  wire logic [3:0]       prescaleShift,
   input  wire logic             loadEn,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic      [WIDTH-1:0] count,
   output logic                  carry
);
   import gtc_pkg::*;

   logic [7:0]       preCnt_r;
   logic [7:0]       preCnt_nxt;
   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   logic [8:0]       preLimit;
   logic             step;
   logic             inc;

   // Prescaler terminal count and the resulting count step.
   assign preLimit = (9'h001 << prescaleShift) - 9'h001;
   assign step     = run & srcTick & gateOk;
   assign inc      = step & ({1'b0, preCnt_r} >= preLimit);
   assign carry    = inc & (count_r == {WIDTH{1'b1}});
   assign count    = count_r;

   // Next prescaler and count; a load also restarts the prescaler.
   always_comb begin
      preCnt_nxt = preCnt_r;
      count_nxt  = count_r;
      if (loadEn) begin
         preCnt_nxt = 8'h00;
         count_nxt  = loadValue;
      end else if (!run) begin
         preCnt_nxt = 8'h00;
      end else if (step) begin
         preCnt_nxt = inc ? 8'h00 : preCnt_r + 8'h01;
         if (inc) begin
            count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // Registers of the core.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         preCnt_r <= 8'h00;
         count_r  <= '0;
      end else begin
         preCnt_r <= preCnt_nxt;
         count_r  <= count_nxt;
      end
   end

endmodule : gtc_timer_core

// >>> design/gtc_top.sv
// Register file and source selection for one standalone and one paired timer.
// Assumes all clock and gate inputs are synchronous to clock.
`timescale 1ns/100ps
`include "gtc_defines.svh"

module gtc_top (
   input  wire logic                 clock,
   input  wire logic                 reset,
   input  wire gtc_pkg::gtc_wb_req_t wbReq,
   input  wire gtc_pkg::gtc_clk_in_t clkIn,
   input  wire logic                 idleMode,
   output logic                      wbAck,
   output logic [31:0]               wbDatOut,
   output logic [15:0]               standaloneCount,
   output logic [15:0]               evenCount,
   output logic [15:0]               oddCount
);
   import gtc_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [15:0]  ctl1_r;
   logic [15:0]  ctl1_nxt;
   logic [15:0]  ctl2_r;
   logic [15:0]  ctl2_nxt;
   logic [15:0]  ctl3_r;
   logic [15:0]  ctl3_nxt;
   logic         ack_r;
   logic         ack_nxt;
   logic [31:0]  dat_r;
   logic [31:0]  dat_nxt;
   logic         pend_r;
   logic         pend_nxt;
   logic [15:0]  hold_r;
   logic [15:0]  hold_nxt;
   gtc_clk_in_t  prev_r;
   gtc_clk_in_t  rise;
   logic         busWrite;
   logic [15:0]  wrVal;
   logic         ext1Tick;
   logic         async1;
   logic         run1;
   logic         tick1;
   logic         gate1;
   logic         load1;
   logic [15:0]  loadVal1;
   logic         wide;
   logic         run2;
   logic         tick2;
   logic         gate2;
   logic         load2;
   logic         carry2;
   logic         run3;
   logic         tick3;
   logic         gate3;
   logic [3:0]   shift3;
   logic         load3;
   logic [15:0]  cnt1;
   logic [15:0]  cnt2;
   logic [15:0]  cnt3;
   logic [15:0]  ctl1View;
   gtc_ext_src_t extSel;

   // ************************************************************
   // Wishbone slave
   // ************************************************************

   // One wait state: ack rises one cycle after the request and drops after.
   assign ack_nxt  = wbReq.cyc & wbReq.stb & ~ack_r;
   assign busWrite = wbReq.cyc & wbReq.stb & wbReq.we & ack_r;
   assign wrVal    = wbReq.dat[15:0];
   assign wbAck    = ack_r;
   assign wbDatOut = dat_r;

   // The pending flag is live only in asynchronous mode.
   always_comb begin
      ctl1View = ctl1_r;
      ctl1View[`GTC_B_WPEND] = pend_r & async1;
   end

   // Read data is captured as the ack is raised; unmapped offsets read zero.
   always_comb begin
      dat_nxt = 32'h0000_0000;
      if (ack_nxt && !wbReq.we) begin
         unique case (wbReq.adr)
            `GTC_OFS_CTL1: dat_nxt = {16'h0000, ctl1View};
            `GTC_OFS_CNT1: dat_nxt = {16'h0000, cnt1};
            `GTC_OFS_CTL2: dat_nxt = {16'h0000, ctl2_r};
            `GTC_OFS_CTL3: dat_nxt = {16'h0000, ctl3_r};
            `GTC_OFS_CNT2: dat_nxt = {16'h0000, cnt2};
            `GTC_OFS_CNT3: dat_nxt = {16'h0000, cnt3};
            default:       dat_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Control register writes under byte enables; masks drop absent bits.
   always_comb begin
      ctl1_nxt = ctl1_r;
      ctl2_nxt = ctl2_r;
      ctl3_nxt = ctl3_r;
      if (busWrite) begin
         unique case (wbReq.adr)
            `GTC_OFS_CTL1: ctl1_nxt = wbMerge(ctl1_r, wbReq.dat, wbReq.sel,
                                              `GTC_MASK_CTL1);
            `GTC_OFS_CTL2: ctl2_nxt = wbMerge(ctl2_r, wbReq.dat, wbReq.sel,
                                              `GTC_MASK_CTL2);
            `GTC_OFS_CTL3: ctl3_nxt = wbMerge(ctl3_r, wbReq.dat, wbReq.sel,
                                              `GTC_MASK_CTL3);
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Standalone timer
   // ************************************************************

   // Rising edges of every external source.
   assign rise = clkIn & ~prev_r;

   // External source choice; the reserved code gives no ticks.
   assign extSel = gtc_ext_src_t'(ctl1_r[`GTC_B_EXT +: 2]);
   always_comb begin
      unique case (extSel)
         EXT_SECONDARY_OSCILLATOR: ext1Tick = rise.secondaryOscillator;
         EXT_PIN:  ext1Tick = rise.standaloneExtClockPin;
         EXT_LOW_POWER_RC_OSC: ext1Tick = rise.lowPowerRcOsc;
         EXT_RSVD: ext1Tick = 1'b0;
      endcase
   end

   // Enable, idle stop, source and gate of the standalone timer.
   assign run1   = ctl1_r[`GTC_B_RUN] & ~(ctl1_r[`GTC_B_HALT] & idleMode);
   assign async1 = ctl1_r[`GTC_B_CSRC] & ~ctl1_r[`GTC_B_SYNC];
   assign tick1  = ctl1_r[`GTC_B_CSRC] ? ext1Tick : 1'b1;
   assign gate1  = ctl1_r[`GTC_B_CSRC] | ~ctl1_r[`GTC_B_GATE]
                   | clkIn.standaloneExtClockPin;

   // Count writes: direct when synchronous, else held until a source edge.
   always_comb begin
      pend_nxt = pend_r;
      hold_nxt = hold_r;
      load1    = 1'b0;
      loadVal1 = hold_r;
      if (pend_r && (ext1Tick || !async1)) begin
         load1    = 1'b1;
         pend_nxt = 1'b0;
      end
      if (busWrite && wbReq.adr == `GTC_OFS_CNT1 && wbReq.sel[1:0] != 2'b00) begin
         if (!async1) begin
            load1    = 1'b1;
            loadVal1 = wbMerge(cnt1, wbReq.dat, wbReq.sel, 16'hFFFF);
         end else if (!(pend_r && ctl1_r[`GTC_B_WBLK])) begin
            pend_nxt = 1'b1;
            hold_nxt = wbMerge(pend_r ? hold_r : cnt1, wbReq.dat, wbReq.sel,
                               16'hFFFF);
         end
      end
   end

   gtc_timer_core #(
      .WIDTH(16)
   ) u_solo (
      .clock         (clock),
      .reset         (reset),
      .run           (run1),
      .srcTick       (tick1),
      .gateOk        (gate1),
      .prescaleShift (soloShift(ctl1_r[`GTC_B_PS +: 2])),
      .loadEn        (load1),
      .loadValue     (loadVal1),
      .count         (cnt1),
      .carry         ()
   );

   // ************************************************************
   // Paired timers
   // ************************************************************

   // Wide mode hands the odd half to the even half's settings; the odd halt-in-idle bit still stops both halves.
   assign wide  = ctl2_r[`GTC_B_WIDE];
   assign run2  = ctl2_r[`GTC_B_RUN] & ~(ctl2_r[`GTC_B_HALT] & idleMode)
                  & ~(wide & ctl3_r[`GTC_B_HALT] & idleMode);
   assign tick2 = ctl2_r[`GTC_B_CSRC] ? rise.evenExtClockPin : 1'b1;
   assign gate2 = ctl2_r[`GTC_B_CSRC] | ~ctl2_r[`GTC_B_GATE]
                  | clkIn.evenExtClockPin;

   // Odd half: own settings alone, or the even half's carry when wide.
   always_comb begin
      if (wide) begin
         run3   = run2;
         tick3  = carry2;
         gate3  = 1'b1;
         shift3 = 4'h0;
      end else begin
         run3   = ctl3_r[`GTC_B_RUN] & ~(ctl3_r[`GTC_B_HALT] & idleMode);
         tick3  = ctl3_r[`GTC_B_CSRC] ? rise.oddExtClockPin : 1'b1;
         gate3  = ctl3_r[`GTC_B_CSRC] | ~ctl3_r[`GTC_B_GATE]
                  | clkIn.oddExtClockPin;
         shift3 = pairShift(ctl3_r[`GTC_B_PS +: 3]);
      end
   end

   assign load2 = busWrite && wbReq.adr == `GTC_OFS_CNT2 && wbReq.sel[1:0] != 2'b00;
   assign load3 = busWrite && wbReq.adr == `GTC_OFS_CNT3 && wbReq.sel[1:0] != 2'b00;

   gtc_timer_core #(
      .WIDTH(16)
   ) u_even (
      .clock         (clock),
      .reset         (reset),
      .run           (run2),
      .srcTick       (tick2),
      .gateOk        (gate2),
      .prescaleShift (pairShift(ctl2_r[`GTC_B_PS +: 3])),
      .loadEn        (load2),
      .loadValue     (wbMerge(cnt2, wbReq.dat, wbReq.sel, 16'hFFFF)),
      .count         (cnt2),
      .carry         (carry2)
   );

   gtc_timer_core #(
      .WIDTH(16)
   ) u_odd (
      .clock         (clock),
      .reset         (reset),
      .run           (run3),
      .srcTick       (tick3),
      .gateOk        (gate3),
      .prescaleShift (shift3),
      .loadEn        (load3),
      .loadValue     (wbMerge(cnt3, wbReq.dat, wbReq.sel, 16'hFFFF)),
      .count         (cnt3),
      .carry         ()
   );

   assign standaloneCount = cnt1;
   assign evenCount       = cnt2;
   assign oddCount        = cnt3;

   // ************************************************************
   // State registers
   // ************************************************************

   // All bus, control and write-hold state.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctl1_r <= `GTC_RST_CTL;
         ctl2_r <= `GTC_RST_CTL;
         ctl3_r <= `GTC_RST_CTL;
         ack_r  <= 1'b0;
         dat_r  <= 32'h0000_0000;
         pend_r <= 1'b0;
         hold_r <= `GTC_RST_CNT;
         prev_r <= '0;
      end else begin
         ctl1_r <= ctl1_nxt;
         ctl2_r <= ctl2_nxt;
         ctl3_r <= ctl3_nxt;
         ack_r  <= ack_nxt;
         dat_r  <= dat_nxt;
         pend_r <= pend_nxt;
         hold_r <= hold_nxt;
         prev_r <= clkIn;
      end
   end

endmodule : gtc_top

// >>> test/gtc_top_props.sv
// Checks bus answers, read masks and even counter stepping.
// Assumes full-word writes with the offsets of gtc_defines.svh.
`timescale 1ns/100ps
`include "gtc_defines.svh"
module gtc_top_props (
   input wire logic                 clock,
   input wire logic                 reset,
   input wire gtc_pkg::gtc_wb_req_t wbReq,
   input wire gtc_pkg::gtc_clk_in_t clkIn,
   input wire logic                 idleMode,
   input wire logic                 wbAck,
   input wire logic [31:0]          wbDatOut,
   input wire logic [15:0]          standaloneCount,
   input wire logic [15:0]          evenCount,
   input wire logic [15:0]          oddCount
);
   import gtc_pkg::*;
   logic [15:0] ctl2_r, ctl2_nxt;
   logic        wr, rd, step;
   // ***********************************
   // Helper logic and assertions
   // ***********************************
   // Mirrors the even control register; step means a plain internal tick.
   always_comb begin
      wr = wbAck && wbReq.we;
      rd = wbAck && !wbReq.we;
      ctl2_nxt = (wr && wbReq.adr == `GTC_OFS_CTL2) ? wbReq.dat[15:0] & 16'hA0FA : ctl2_r;
      step = ctl2_r[15] && (ctl2_r & 16'h00F2) == 16'h0000 && !idleMode && !wr;
   end
   // Registers the mirror.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) ctl2_r <= 16'h0000;
      else ctl2_r <= ctl2_nxt;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   ack_latency_a: assert property ($rose(wbReq.cyc && wbReq.stb) |=> wbAck)
      else $error("Bus answer is late.");
   ack_pulse_a: assert property (wbAck |=> !wbAck)
      else $error("Bus answer stands too long.");
   dat_idle_a: assert property (!wbAck |-> wbDatOut == 32'h0)
      else $error("Read data outside an answer.");
   ctl1_mask_a: assert property (rd && wbReq.adr == `GTC_OFS_CTL1 |->
      (wbDatOut & ~32'h0000BBB6) == 32'h0) else $error("Unused standalone bits set.");
   ctl2_mask_a: assert property (rd && wbReq.adr == `GTC_OFS_CTL2 |->
      (wbDatOut & ~32'h0000A0FA) == 32'h0) else $error("Unused even bits set.");
   ctl3_nowide_a: assert property (rd && wbReq.adr == `GTC_OFS_CTL3 |->
      (wbDatOut & ~32'h0000A0F2) == 32'h0) else $error("Odd control shows wide bit.");
   even_hold_a: assert property ((!ctl2_r[15] || ctl2_r[13] && idleMode) && !wr
      |=> $stable(evenCount)) else $error("Stopped even counter moved.");
   even_step_a: assert property (step |=> evenCount == $past(evenCount) + 16'h1)
      else $error("Even counter missed a tick.");
   wide_carry_a: assert property (step && ctl2_r[3] && evenCount == 16'hFFFF
      |=> oddCount == $past(oddCount) + 16'h1) else $error("Wide carry lost.");
endmodule : gtc_top_props
bind gtc_top gtc_top_props i_gtc_top_props (.clock, .reset, .wbReq, .clkIn, .idleMode,
   .wbAck, .wbDatOut, .standaloneCount, .evenCount, .oddCount);

// >>> test/tb_top.sv
// Self-checking bench for the timer block over Wishbone and source inputs.
// Assumes package, design and checker are compiled before it.
`timescale 1ns/100ps
`include "gtc_defines.svh"
module tb_top;
   import gtc_pkg::*;
   logic        clock, reset, idleMode, wbAck;
   gtc_wb_req_t wbReq;
   gtc_clk_in_t clkIn;
   logic [31:0] wbDatOut, rdat;
   logic [15:0] standaloneCount, evenCount, oddCount, sd, c0;
   int          fails, cmp_count;
   int          div [12] = '{1, 8, 64, 256, 1, 2, 4, 8, 16, 32, 64, 256};
   int          ex [4] = '{1, 3, 2, 0};
   gtc_top i_gtc_top (.clock, .reset, .wbReq, .clkIn, .idleMode, .wbAck, .wbDatOut,
                      .standaloneCount, .evenCount, .oddCount);
   // ***********************************
   // Support tasks
   // ***********************************
   // Free-running system clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Compares and counts.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   // Prints the verdict and ends the run.
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // One classic cycle; the request stands until ack is sampled.
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] dat);
      int n;
      @(posedge clock);
      wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, {16'h0000, dat}};
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rdat = wbDatOut;
      wbReq.cyc <= 1'b0;
      wbReq.stb <= 1'b0;
      if (n >= 50) begin
         fails++;
         wrap_up;
      end
   endtask : xfer
   task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
      xfer(1'b1, adr, dat);
   endtask : wr
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      xfer(1'b0, adr, 16'h0000);
      check(rdat, exp);
   endtask : rd
   // Stops all three timers.
   task automatic zero;
      wr(`GTC_OFS_CTL1, 16'h0000);
      wr(`GTC_OFS_CTL2, 16'h0000);
      wr(`GTC_OFS_CTL3, 16'h0000);
   endtask : zero
   function automatic logic [15:0] cnt(input int w);
      return (w == 0) ? standaloneCount : (w == 1) ? evenCount : oddCount;
   endfunction : cnt
   // Counter advance over n cycles, after a short settling gap.
   task automatic span(input int w, input int n);
      repeat (3) @(posedge clock);
      c0 = cnt(w);
      repeat (n) @(posedge clock);
      sd = cnt(w) - c0;
   endtask : span
   // Gives n rising edges on source k, counted from the top of clkIn.
   task automatic pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clock);
         clkIn <= 5'b10000 >> k;
         repeat (2) @(posedge clock);
         clkIn <= 5'h00;
      end
      repeat (3) @(posedge clock);
   endtask : pulse
   // ***********************************
   // Scenarios
   // ***********************************
   task automatic t_regs;
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
      wr(`GTC_OFS_CTL1, 16'h7FFF);
      wr(`GTC_OFS_CTL2, 16'h7FFF);
      wr(`GTC_OFS_CTL3, 16'h7FFF);
      wr(8'h18, 16'hFFFF);
      rd(`GTC_OFS_CTL1, 32'h33B6);
      rd(`GTC_OFS_CTL2, 32'h20FA);
      rd(`GTC_OFS_CTL3, 32'h20F2);
      rd(8'h18, 32'h0);
      zero;
      $display("Register test done.");
   endtask : t_regs
   task automatic t_prescale;
      for (int i = 0; i < 12; i++) begin
         if (i < 4) wr(`GTC_OFS_CTL1, 16'h8004 | 16'(i << 4));
         else wr(`GTC_OFS_CTL2, 16'h8000 | 16'((i - 4) << 4));
         span(i < 4 ? 0 : 1, 4 * div[i]);
         check({16'h0, sd}, 32'h4);
      end
      zero;
      span(1, 20);
      check({16'h0, sd}, 32'h0);
      $display("Prescale test done.");
   endtask : t_prescale
   task automatic t_ext;
      for (int i = 0; i < 4; i++) begin
         wr(`GTC_OFS_CTL1, 16'h8086 | 16'(i << 8));
         c0 = standaloneCount;
         pulse(0, 1);
         pulse(1, 2);
         pulse(2, 3);
         check({16'h0, standaloneCount - c0}, 32'(ex[i]));
      end
      // Even timer on its own pin; the gate bit must be ignored.
      wr(`GTC_OFS_CTL2, 16'h8082);
      @(posedge clock);
      c0 = evenCount;
      pulse(3, 2);
      check({16'h0, evenCount - c0}, 32'h2);
      wr(`GTC_OFS_CTL2, 16'h0000);
      $display("Source select test done.");
   endtask : t_ext
   task automatic t_async;
      wr(`GTC_OFS_CTL1, 16'h9032);
      wr(`GTC_OFS_CNT1, 16'h1234);
      rd(`GTC_OFS_CTL1, 32'h9832);
      wr(`GTC_OFS_CNT1, 16'h5555);
      pulse(0, 1);
      rd(`GTC_OFS_CTL1, 32'h9032);
      rd(`GTC_OFS_CNT1, 32'h1234);
      wr(`GTC_OFS_CTL1, 16'h8032);
      wr(`GTC_OFS_CNT1, 16'h1111);
      wr(`GTC_OFS_CNT1, 16'h2222);
      pulse(0, 1);
      rd(`GTC_OFS_CNT1, 32'h2222);
      zero;
      $display("Async write test done.");
   endtask : t_async
   task automatic t_gate;
      wr(`GTC_OFS_CTL3, 16'h8080);
      span(2, 20);
      check({16'h0, sd}, 32'h0);
      clkIn <= 5'h01;
      span(2, 20);
      check({16'h0, sd}, 32'h14);
      clkIn <= 5'h00;
      wr(`GTC_OFS_CTL3, 16'hA000);
      idleMode <= 1'b1;
      span(2, 20);
      check({16'h0, sd}, 32'h0);
      wr(`GTC_OFS_CTL3, 16'h8000);
      span(2, 20);
      check({16'h0, sd}, 32'h14);
      idleMode <= 1'b0;
      wr(`GTC_OFS_CTL3, 16'h8082);
      // The old internal setting still counts on the edge the write lands.
      @(posedge clock);
      c0 = oddCount;
      pulse(4, 3);
      check({16'h0, oddCount - c0}, 32'h3);
      zero;
      $display("Gate and idle test done.");
   endtask : t_gate
   task automatic t_wide;
      wr(`GTC_OFS_CTL3, 16'h0002);
      wr(`GTC_OFS_CNT2, 16'hFFFC);
      wr(`GTC_OFS_CNT3, 16'h0007);
      wr(`GTC_OFS_CTL2, 16'h8008);
      repeat (10) @(posedge clock);
      wr(`GTC_OFS_CTL2, 16'h0008);
      rd(`GTC_OFS_CNT3, 32'h0008);
      zero;
      $display("Wide mode test done.");
   endtask : t_wide
   // Reset in mid-run clears controls and counts.
   task automatic t_reset;
      wr(`GTC_OFS_CTL2, 16'h8000);
      repeat (5) @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      check({16'h0, evenCount}, 32'h0);
      rd(`GTC_OFS_CTL2, 32'h0);
      span(1, 20);
      check({16'h0, sd}, 32'h0);
      $display("Reset test done.");
   endtask : t_reset
   // Main sequence after six cycles of reset.
   initial begin
      reset = 1'b1;
      idleMode = 1'b0;
      wbReq = '0;
      clkIn = '0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      t_regs;
      t_prescale;
      t_ext;
      t_async;
      t_gate;
      t_wide;
      t_reset;
      wrap_up;
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      #100000;
      fails++;
      wrap_up;
   end
endmodule : tb_top
